// >>> verilog/dsr_pkg.sv
// Package for the drive status readout register bank.
// Assumes a host command parser that addresses registers by their index.
package dsr_pkg;
  // Register indices as addressed by the read command
  localparam logic [7:0] IDX_ANALOG_ONE   = 8'h3a;
  localparam logic [7:0] IDX_ANALOG_TWO   = 8'h3b;
  localparam logic [7:0] IDX_TRAJ_POS     = 8'h3c;
  localparam logic [7:0] IDX_CMD_MODE     = 8'h3d;
  localparam logic [7:0] IDX_VEL_STATE    = 8'h3e;
  localparam logic [7:0] IDX_PT_STATE     = 8'h3f;
  localparam logic [7:0] IDX_SEGMENT      = 8'h40;
  localparam logic [7:0] IDX_MOTOR_CUR    = 8'h41;
  localparam logic [7:0] IDX_CLAMP_PWR    = 8'h42;
  localparam logic [7:0] IDX_STATUS_CODE  = 8'h43;
  localparam logic [7:0] IDX_TEMPERATURE  = 8'h44;
  localparam logic [7:0] IDX_BUS_VOLT     = 8'h45;
  localparam logic [7:0] IDX_ACT_VEL      = 8'h46;
  localparam logic [7:0] IDX_TGT_VEL      = 8'h47;
  localparam logic [7:0] IDX_POS_ERR      = 8'h48;
  localparam logic [7:0] IDX_EXP_INPUTS   = 8'h49;
  localparam logic [7:0] IDX_PHASE_ERR    = 8'h4a;
  localparam logic [7:0] IDX_IO_SNAPSHOT  = 8'h4b;
  // Snapshot layouts
  localparam logic [1:0] LAYOUT_ONE   = 2'h0;
  localparam logic [1:0] LAYOUT_TWO   = 2'h1;
  localparam logic [1:0] LAYOUT_THREE = 2'h2;
  localparam logic [1:0] LAYOUT_FOUR  = 2'h3;
  // Field positions
  localparam int L1_OUT_POS   = 8;
  localparam int L2_OUT_POS   = 8;
  localparam int L2_IDX_POS   = 12;
  localparam int L3_OUT_POS   = 8;
  localparam int L4_OUT_POS   = 8;
  localparam int L4_IDX_POS   = 14;
  localparam int EXP_OUT_POS  = 8;
  localparam int EXP_ID_POS   = 15;
  // Analog count limits
  localparam logic [15:0] ADC_MAX   = 16'h7ff8;
  localparam logic [15:0] ADC_ZERO  = 16'h3fff;
  // Reset values
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [31:0] RST_LONG  = 32'h0000_0000;
  // Timing: one PWM period
  localparam int CLK_MHZ        = 125;
  localparam int PWM_PERIOD_US  = 62;
  localparam int PWM_CYCLES     = PWM_PERIOD_US * CLK_MHZ;
  // Velocity move states
  typedef enum logic [3:0] {
    VS_WAITING  = 4'h0,
    VS_RUNNING  = 4'h1,
    VS_FAST     = 4'h2,
    VS_STOPPING = 4'h3,
    VS_ENDING   = 4'h4
  } dsr_vel_type;
  // Point-to-point move states
  typedef enum logic [3:0] {
    PS_WAITING  = 4'h0,
    PS_BRAKE    = 4'h1,
    PS_CALC     = 4'h2,
    PS_ACCEL    = 4'h3,
    PS_CHANGE   = 4'h4,
    PS_AT_VEL   = 4'h5,
    PS_DECEL    = 4'h6,
    PS_FAST_DEC = 4'h7,
    PS_POSITION = 4'h8
  } dsr_pt_type;
endpackage

// >>> verilog/dsr_regs.sv
// Drive status readout: read-only status registers and move state codes.
// Assumes motion core events on clk_sys; isolated pins are asynchronous.
//
// Overview of operation
// - Layout one: index bit0, inputs 1-7, outputs 8-10
// - Layout one: inputs one when open, outputs inverse
// - Layout two: inputs 0-7, outputs 8-11, index 12
// - Layout two: inputs open one, outputs closed one
// - Layout three: index, step, dir, enable, output bit8
// - Layout three: bits 0-3 one when open
// - Layout four: inputs 0-3, outputs 8-9, index 14
// - Analog counts 0 to 32760, 16383 zero volts
// - Velocity state codes zero through four
// - Ending states last one 62 us period
// - Point state codes zero through eight
// - Point state meaningful only during feed moves
// - Brake wait state one before calculating
// - Immediate stop or kill in point move gives seven
// - Expanded inputs 0-7, outputs 8-11, 12-14 unused
// - Expanded I/O bits one when open
// - Bit 15 shows expansion board presence
// - Stepper target velocity updates only with stall option
// - Thirty-two bit trajectory position register
`timescale 1ns/1ps
module dsr_regs
(
  input  wire logic        clk_sys,             // System clock, 125 MHz
  input  wire logic        sys_rst,             // Asynchronous reset, high
  input  wire logic [1:0]  layout_sel,          // Snapshot layout variant
  input  wire logic        stepper_variant,     // High on stepper drives
  input  wire logic        stall_enable,        // Stall detect or prevent on
  input  wire logic        index_input,         // Encoder index pin, low = closed
  input  wire logic [7:0]  iso_input,           // Isolated inputs, 1 = open
  input  wire logic [3:0]  iso_output_closed,   // Output drive, 1 = closed
  input  wire logic        step_input,          // Step pin, 1 = open
  input  wire logic        dir_input,           // Direction pin, 1 = open
  input  wire logic        enable_input,        // Enable pin, 1 = open
  input  wire logic [7:0]  top_input,           // Top board inputs, 1 = open
  input  wire logic [3:0]  top_output_open,     // Driver board outputs, 1 = open
  input  wire logic        board_present,       // Expansion board fitted
  input  wire logic [15:0] analog_read_one,     // Raw converter count one
  input  wire logic [15:0] analog_read_two,     // Raw converter count two
  input  wire logic [31:0] traj_position,       // Trajectory position
  input  wire logic [15:0] cmd_mode,            // Command mode number
  input  wire logic [15:0] segment_in,          // Segment number
  input  wire logic [15:0] motor_current_in,    // Motor current
  input  wire logic [15:0] clamp_power_in,      // Clamp power
  input  wire logic [15:0] status_code_in,      // Status code
  input  wire logic [15:0] temperature_in,      // Temperature
  input  wire logic [15:0] bus_voltage_in,      // Bus voltage
  input  wire logic [15:0] act_velocity_in,     // Actual velocity
  input  wire logic [15:0] tgt_velocity_in,     // Target velocity
  input  wire logic [31:0] pos_error_in,        // Position error
  input  wire logic [15:0] phase_error_in,      // Phase error
  input  wire logic        jog_start,           // Jog command pulse
  input  wire logic        stop_jog_cmd,        // Controlled jog stop pulse
  input  wire logic        decel_stop_cmd,      // Decelerating stop pulse
  input  wire logic        decel_kill_cmd,      // Decelerating kill pulse
  input  wire logic        immediate_stop_cmd,  // Immediate stop pulse
  input  wire logic        kill_cmd,            // Kill pulse
  input  wire logic        motion_done,         // Motion reached zero speed
  input  wire logic        feed_length_cmd,     // Feed to length pulse
  input  wire logic        feed_position_cmd,   // Feed to position pulse
  input  wire logic        feed_sensor_cmd,     // Feed to sensor pulse
  input  wire logic        brake_released,      // Brake released level
  input  wire logic        calc_done,           // Move calculation done
  input  wire logic        at_speed,            // Accel finished
  input  wire logic        speed_change,        // Speed change requested
  input  wire logic        decel_start,         // Decel begins
  input  wire logic        rd_en,               // Read request pulse
  input  wire logic [7:0]  rd_index,            // Register index to read
  input  wire logic        wr_en,               // Write attempt pulse
  output logic             rd_valid,            // Read answer valid pulse
  output logic             rd_error,            // Unmapped index pulse
  output logic [31:0]      rd_data              // Read answer word
);

  // Two-stage synchronisers for every pin input
  localparam int PINS = 35;
  logic [PINS-1:0] pin_raw;     // Raw pin vector
  logic [PINS-1:0] pin_meta;    // First stage
  logic [PINS-1:0] pin_sync;    // Second stage, the only reader of first
  assign pin_raw = {board_present, top_output_open, top_input, enable_input, dir_input,
                    step_input, iso_output_closed, iso_input, index_input, 6'h00};

  // Synchroniser chain
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  logic       s_index;          // Synchronised index
  logic [7:0] s_in;             // Synchronised inputs
  logic [3:0] s_out;            // Synchronised output closed states
  logic       s_step;           // Synchronised step
  logic       s_dir;            // Synchronised direction
  logic       s_en;             // Synchronised enable
  logic [7:0] s_top;            // Synchronised top inputs
  logic [3:0] s_topout;         // Synchronised top outputs
  logic       s_present;        // Synchronised board presence
  assign {s_present, s_topout, s_top, s_en, s_dir, s_step, s_out, s_in, s_index} = pin_sync[PINS-1:6];

  // Snapshot word per layout
  logic [15:0] snap_next;
  always_comb
  begin
    snap_next = dsr_pkg::RST_WORD;
    case (layout_sel)
      dsr_pkg::LAYOUT_ONE:
      begin
        snap_next[0] = s_index;
        snap_next[7:1] = s_in[6:0];
        snap_next[dsr_pkg::L1_OUT_POS +: 3] = s_out[2:0];
      end
      dsr_pkg::LAYOUT_TWO:
      begin
        snap_next[7:0] = s_in;
        snap_next[dsr_pkg::L2_OUT_POS +: 4] = s_out;
        snap_next[dsr_pkg::L2_IDX_POS] = s_index;
      end
      dsr_pkg::LAYOUT_THREE:
      begin
        snap_next[3:0] = {s_en, s_dir, s_step, s_index};
        snap_next[dsr_pkg::L3_OUT_POS] = s_out[0];
      end
      default:
      begin
        snap_next[3:0] = s_in[3:0];
        snap_next[dsr_pkg::L4_OUT_POS +: 2] = s_out[1:0];
        snap_next[dsr_pkg::L4_IDX_POS] = s_index;
      end
    endcase
  end

  // Expanded-input word
  logic [15:0] exp_next;
  always_comb
  begin
    exp_next = dsr_pkg::RST_WORD;
    exp_next[7:0] = s_top;
    exp_next[dsr_pkg::EXP_OUT_POS +: 4] = s_topout;
    exp_next[dsr_pkg::EXP_ID_POS] = s_present;
  end

  // Clamp a converter count into the legal range
  function automatic logic [15:0] adc_clamp(input logic [15:0] c);
    adc_clamp = (c > dsr_pkg::ADC_MAX) ? dsr_pkg::ADC_MAX : c;
  endfunction

  // Sampled status registers
  logic [15:0] snap_reg;
  logic [15:0] exp_reg;
  logic [15:0] an1_reg;
  logic [15:0] an2_reg;
  logic [15:0] tgt_vel_reg;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      snap_reg    <= dsr_pkg::RST_WORD;
      exp_reg     <= dsr_pkg::RST_WORD;
      an1_reg     <= dsr_pkg::ADC_ZERO;
      an2_reg     <= dsr_pkg::ADC_ZERO;
      tgt_vel_reg <= dsr_pkg::RST_WORD;
    end
    else
    begin
      snap_reg <= snap_next;
      exp_reg  <= exp_next;
      an1_reg  <= adc_clamp(analog_read_one);
      an2_reg  <= adc_clamp(analog_read_two);
      if (!stepper_variant || stall_enable)
      begin
        tgt_vel_reg <= tgt_velocity_in;
      end
    end
  end

  // PWM-period counters for the ending states
  localparam logic [13:0] END_LAST = 14'(dsr_pkg::PWM_CYCLES - 1);
  logic [13:0] vel_cnt_reg;
  logic [13:0] pt_cnt_reg;

  // Velocity move state machine
  dsr_pkg::dsr_vel_type vel_reg;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vel_reg     <= dsr_pkg::VS_WAITING;
      vel_cnt_reg <= '0;
    end
    else
    begin
      case (vel_reg)
        dsr_pkg::VS_WAITING:
        begin
          if (jog_start)
          begin
            vel_reg <= dsr_pkg::VS_RUNNING;
          end
        end
        dsr_pkg::VS_RUNNING:
        begin
          if (immediate_stop_cmd || kill_cmd)
          begin
            vel_reg <= dsr_pkg::VS_FAST;
          end
          else if (stop_jog_cmd || decel_stop_cmd || decel_kill_cmd)
          begin
            vel_reg <= dsr_pkg::VS_STOPPING;
          end
        end
        dsr_pkg::VS_FAST, dsr_pkg::VS_STOPPING:
        begin
          if (immediate_stop_cmd || kill_cmd)
          begin
            vel_reg <= dsr_pkg::VS_FAST;
          end
          else if (motion_done)
          begin
            vel_reg     <= dsr_pkg::VS_ENDING;
            vel_cnt_reg <= '0;
          end
        end
        dsr_pkg::VS_ENDING:
        begin
          if (vel_cnt_reg == END_LAST)
          begin
            vel_reg <= dsr_pkg::VS_WAITING;
          end
          else
          begin
            vel_cnt_reg <= vel_cnt_reg + 14'h0001;
          end
        end
        default:
        begin
          vel_reg <= dsr_pkg::VS_WAITING;
        end
      endcase
    end
  end

  // Point-to-point move state machine
  dsr_pkg::dsr_pt_type pt_reg;
  logic feed_start;
  logic pt_stop;
  assign feed_start = feed_length_cmd || feed_position_cmd || feed_sensor_cmd;
  assign pt_stop    = immediate_stop_cmd || kill_cmd;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pt_reg     <= dsr_pkg::PS_WAITING;
      pt_cnt_reg <= '0;
    end
    else
    begin
      case (pt_reg)
        dsr_pkg::PS_WAITING:
        begin
          if (feed_start)
          begin
            pt_reg <= dsr_pkg::PS_BRAKE;
          end
        end
        dsr_pkg::PS_BRAKE:
        begin
          if (pt_stop)
          begin
            pt_reg <= dsr_pkg::PS_FAST_DEC;
          end
          else if (brake_released)
          begin
            pt_reg <= dsr_pkg::PS_CALC;
          end
        end
        dsr_pkg::PS_CALC:
        begin
          if (pt_stop)
          begin
            pt_reg <= dsr_pkg::PS_FAST_DEC;
          end
          else if (calc_done)
          begin
            pt_reg <= dsr_pkg::PS_ACCEL;
          end
        end
        dsr_pkg::PS_ACCEL, dsr_pkg::PS_CHANGE, dsr_pkg::PS_AT_VEL:
        begin
          if (pt_stop)
          begin
            pt_reg <= dsr_pkg::PS_FAST_DEC;
          end
          else if (decel_start)
          begin
            pt_reg <= dsr_pkg::PS_DECEL;
          end
          else if (speed_change)
          begin
            pt_reg <= dsr_pkg::PS_CHANGE;
          end
          else if (at_speed)
          begin
            pt_reg <= dsr_pkg::PS_AT_VEL;
          end
        end
        dsr_pkg::PS_DECEL, dsr_pkg::PS_FAST_DEC:
        begin
          if (pt_stop)
          begin
            pt_reg <= dsr_pkg::PS_FAST_DEC;
          end
          else if (motion_done)
          begin
            pt_reg     <= dsr_pkg::PS_POSITION;
            pt_cnt_reg <= '0;
          end
        end
        dsr_pkg::PS_POSITION:
        begin
          if (pt_cnt_reg == END_LAST)
          begin
            pt_reg <= dsr_pkg::PS_WAITING;
          end
          else
          begin
            pt_cnt_reg <= pt_cnt_reg + 14'h0001;
          end
        end
        default:
        begin
          pt_reg <= dsr_pkg::PS_WAITING;
        end
      endcase
    end
  end

  // Read decode; writes never touch any register
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = dsr_pkg::RST_LONG;
    if (rd_index == dsr_pkg::IDX_ANALOG_ONE)        rd_word = {16'h0000, an1_reg};
    else if (rd_index == dsr_pkg::IDX_ANALOG_TWO)   rd_word = {16'h0000, an2_reg};
    else if (rd_index == dsr_pkg::IDX_TRAJ_POS)     rd_word = traj_position;
    else if (rd_index == dsr_pkg::IDX_CMD_MODE)     rd_word = {16'h0000, cmd_mode};
    else if (rd_index == dsr_pkg::IDX_VEL_STATE)    rd_word = {28'h0000000, vel_reg};
    else if (rd_index == dsr_pkg::IDX_PT_STATE)     rd_word = {28'h0000000, pt_reg};
    else if (rd_index == dsr_pkg::IDX_SEGMENT)      rd_word = {16'h0000, segment_in};
    else if (rd_index == dsr_pkg::IDX_MOTOR_CUR)    rd_word = {16'h0000, motor_current_in};
    else if (rd_index == dsr_pkg::IDX_CLAMP_PWR)    rd_word = {16'h0000, clamp_power_in};
    else if (rd_index == dsr_pkg::IDX_STATUS_CODE)  rd_word = {16'h0000, status_code_in};
    else if (rd_index == dsr_pkg::IDX_TEMPERATURE)  rd_word = {16'h0000, temperature_in};
    else if (rd_index == dsr_pkg::IDX_BUS_VOLT)     rd_word = {16'h0000, bus_voltage_in};
    else if (rd_index == dsr_pkg::IDX_ACT_VEL)      rd_word = {16'h0000, act_velocity_in};
    else if (rd_index == dsr_pkg::IDX_TGT_VEL)      rd_word = {16'h0000, tgt_vel_reg};
    else if (rd_index == dsr_pkg::IDX_POS_ERR)      rd_word = pos_error_in;
    else if (rd_index == dsr_pkg::IDX_EXP_INPUTS)   rd_word = {16'h0000, exp_reg};
    else if (rd_index == dsr_pkg::IDX_PHASE_ERR)    rd_word = {16'h0000, phase_error_in};
    else if (rd_index == dsr_pkg::IDX_IO_SNAPSHOT)  rd_word = {16'h0000, snap_reg};
    else rd_hit = 1'b0;
  end

  // Registered read answer; wr_en is deliberately not used by any register
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_valid <= 1'b0;
      rd_error <= 1'b0;
      rd_data  <= dsr_pkg::RST_LONG;
    end
    else
    begin
      rd_valid <= rd_en && rd_hit;
      rd_error <= rd_en && !rd_hit;
      if (rd_en)
      begin
        rd_data <= rd_word;
      end
    end
  end

  // Assertions
  // Helper count of cycles spent in the velocity ending state, kept apart from the machine's own counter
  logic [13:0] vel_end_seen_reg;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      vel_end_seen_reg <= '0;
    else
      vel_end_seen_reg <= (vel_reg == dsr_pkg::VS_ENDING) ? vel_end_seen_reg + 14'h0001 : 14'h0000;
  end
  a_ending_one_period: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vel_reg == dsr_pkg::VS_WAITING && $past(vel_reg) == dsr_pkg::VS_ENDING)
      |-> ($past(vel_end_seen_reg) == END_LAST))
    else $error("velocity ending state too short");
  a_ending_no_overrun: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vel_reg == dsr_pkg::VS_ENDING) |-> (vel_end_seen_reg <= END_LAST))
    else $error("velocity ending state too long");
  a_vel_fast_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vel_reg == dsr_pkg::VS_RUNNING && immediate_stop_cmd) |=> (vel_reg == dsr_pkg::VS_FAST))
    else $error("immediate stop did not fast stop");
  a_vel_decel_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vel_reg == dsr_pkg::VS_RUNNING && !immediate_stop_cmd && !kill_cmd && stop_jog_cmd)
      |=> (vel_reg == dsr_pkg::VS_STOPPING))
    else $error("jog stop did not decelerate");
  a_vel_code_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vel_reg <= 4'h4)
    else $error("velocity state code out of range");
  a_pt_code_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pt_reg <= 4'h8)
    else $error("point state code out of range");
  a_pt_brake_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pt_reg == dsr_pkg::PS_WAITING && feed_start) |=> (pt_reg == dsr_pkg::PS_BRAKE))
    else $error("feed move skipped brake wait");
  a_pt_kill_fast: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pt_reg != dsr_pkg::PS_WAITING && pt_reg != dsr_pkg::PS_POSITION && pt_stop)
      |=> (pt_reg == dsr_pkg::PS_FAST_DEC))
    else $error("stop in point move not fast decel");
  a_exp_presence: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_en && rd_index == dsr_pkg::IDX_EXP_INPUTS) |=> (rd_data[15] == $past(exp_reg[15]) && rd_data[14:12] == 3'h0))
    else $error("expanded presence bit wrong");
  a_analog_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rd_valid && $past(rd_index) == dsr_pkg::IDX_ANALOG_ONE) |-> (rd_data <= 32'h0000_7ff8))
    else $error("analog count above limit");
  a_write_ignored: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_en && !rd_en) |=> $stable(rd_data))
    else $error("write changed read data");
endmodule

// >>> bench/dsr_host.sv
// Host model: issues register reads and write attempts to the bank.
// Assumes answers come a cycle after the taking edge.
`timescale 1ns/1ps
module dsr_host
(
  input  wire logic        clk_sys,
  input  wire logic        rd_valid,
  input  wire logic        rd_error,
  input  wire logic [31:0] rd_data,
  output logic             rd_en,
  output logic [7:0]       rd_index,
  output logic             wr_en
);
  // Idle bus at time zero
  initial
  begin
    rd_en = 1'b0;
    rd_index = 8'h00;
    wr_en = 1'b0;
  end
  // One read; the index is scrambled once taken so no stale value lingers
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic e, output logic tmo);
    tmo = 1'b1;
    d = 32'h0;
    e = 1'b0;
    @(posedge clk_sys);
    rd_en <= 1'b1;
    rd_index <= idx;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    rd_index <= ~idx;
    for (int n = 0; n < 4 && tmo; n++)
    begin
      @(posedge clk_sys);
      if (rd_valid === 1'b1 || rd_error === 1'b1)
      begin
        tmo = 1'b0;
        d = rd_data;
        e = rd_error;
      end
    end
  endtask
  // Write attempt to a status register
  task automatic wr(input logic [7:0] idx);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    rd_index <= idx;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // Drop the presence flag and unused top bits before use
  function automatic logic [31:0] mask_exp(input logic [31:0] d);
    return d & 32'h0000_0fff;
  endfunction
endmodule

// >>> bench/drive_status_readout_registers_test.sv
// Bench for the status readout bank: layouts, analog, live values, move states.
// Assumes the host model is compiled first.
`timescale 1ns/1ps
module drive_status_readout_registers_test;
  logic        clk_sys;          // System clock
  logic        sys_rst;          // Reset, high
  logic [1:0]  layout_sel;       // Snapshot layout
  logic        stepper_variant;  // Stepper drive
  logic        stall_enable;     // Stall option
  logic [15:0] pins;             // Index, inputs, outputs, step, dir, enable
  logic [12:0] ext;              // Top inputs, driver outputs, board flag
  logic [15:0] ana;              // Analog count; input two sees its inverse
  logic [31:0] live;             // Live telemetry
  logic [14:0] ev;               // Move events
  logic        rd_en;            // Read request
  logic [7:0]  rd_index;         // Register index
  logic        wr_en;            // Write attempt
  logic        rd_valid;         // Answer valid
  logic        rd_error;         // Unmapped answer
  logic [31:0] rd_data;          // Answer word
  int          fails;            // Mismatch count
  int          checks_done;      // Comparison count
  dsr_regs u_dsr_regs
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .layout_sel(layout_sel), .stepper_variant(stepper_variant),
    .stall_enable(stall_enable), .index_input(pins[0]), .iso_input(pins[8:1]), .iso_output_closed(pins[12:9]),
    .step_input(pins[13]), .dir_input(pins[14]), .enable_input(pins[15]), .top_input(ext[7:0]),
    .top_output_open(ext[11:8]), .board_present(ext[12]), .analog_read_one(ana), .analog_read_two(~ana),
    .traj_position(live), .cmd_mode(live[15:0]), .segment_in(live[15:0]), .motor_current_in(live[15:0]),
    .clamp_power_in(live[15:0]), .status_code_in(live[15:0]), .temperature_in(live[15:0]),
    .bus_voltage_in(live[15:0]), .act_velocity_in(live[15:0]), .tgt_velocity_in(live[15:0]),
    .pos_error_in(live), .phase_error_in(live[15:0]), .jog_start(ev[0]), .stop_jog_cmd(ev[1]),
    .decel_stop_cmd(ev[2]), .decel_kill_cmd(ev[3]), .immediate_stop_cmd(ev[4]), .kill_cmd(ev[5]),
    .motion_done(ev[6]), .feed_length_cmd(ev[7]), .feed_position_cmd(ev[8]), .feed_sensor_cmd(ev[9]),
    .brake_released(ev[10]), .calc_done(ev[11]), .at_speed(ev[12]), .speed_change(ev[13]),
    .decel_start(ev[14]), .rd_en(rd_en), .rd_index(rd_index), .wr_en(wr_en), .rd_valid(rd_valid),
    .rd_error(rd_error), .rd_data(rd_data)
  );
  dsr_host u_dsr_host
  (
    .clk_sys(clk_sys), .rd_valid(rd_valid), .rd_error(rd_error), .rd_data(rd_data), .rd_en(rd_en),
    .rd_index(rd_index), .wr_en(wr_en)
  );
  // Free-running clock, 8 ns
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  // Read and compare data and error flag; a hung read ends the run
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic experr, output logic [31:0] d);
    logic e;
    logic t;
    u_dsr_host.rd(idx, d, e, t);
    if (t)
    begin
      fails++;
      complete_run();
    end
    else
    begin
      chk(d, exp);
      chk({31'h0, e}, {31'h0, experr});
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One-cycle event pulse
  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev <= 15'h1 << k;
    @(posedge clk_sys);
    ev <= 15'h0;
  endtask
  // Expected snapshot word for a layout
  function automatic logic [31:0] snap(input logic [1:0] l);
    case (l)
      2'h0: return {16'h0, 5'h0, pins[11:9], pins[7:1], pins[0]};
      2'h1: return {16'h0, 3'h0, pins[0], pins[12:9], pins[8:1]};
      2'h2: return {16'h0, 7'h0, pins[9], 4'h0, pins[15:13], pins[0]};
      default: return {16'h0, 1'b0, pins[0], 4'h0, pins[10:9], 4'h0, pins[4:1]};
    endcase
  endfunction
  // Every layout, two complementary pin patterns, plus expanded inputs
  task automatic t_layouts();
    logic [31:0] d;
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk_sys);
      pins <= p ? 16'h5a3c : 16'ha5c3;
      ext <= p ? 13'h1a5c : 13'h05a3;
      for (int l = 0; l < 4; l++)
      begin
        @(posedge clk_sys);
        layout_sel <= 2'(l);
        cyc(4);
        rchk(dsr_pkg::IDX_IO_SNAPSHOT, snap(2'(l)), 1'b0, d);
      end
      rchk(dsr_pkg::IDX_EXP_INPUTS, {16'h0, ext[12], 3'h0, ext[11:0]}, 1'b0, d);
      chk(u_dsr_host.mask_exp(d), {20'h0, ext[11:0]});
    end
  endtask
  // Clamp above and exactly at the top count, live values, target hold, unmapped
  task automatic t_values();
    logic [31:0] d;
    @(posedge clk_sys);
    ana <= 16'h8007;
    stepper_variant <= 1'b1;
    live <= 32'h1357_9bdf;
    cyc(3);
    rchk(dsr_pkg::IDX_ANALOG_ONE, 32'h7ff8, 1'b0, d);
    rchk(dsr_pkg::IDX_ANALOG_TWO, 32'h7ff8, 1'b0, d);
    rchk(dsr_pkg::IDX_TRAJ_POS, 32'h1357_9bdf, 1'b0, d);
    rchk(dsr_pkg::IDX_TGT_VEL, 32'h0, 1'b0, d);
    @(posedge clk_sys);
    stall_enable <= 1'b1;
    cyc(2);
    rchk(dsr_pkg::IDX_TGT_VEL, 32'h9bdf, 1'b0, d);
    // Every live telemetry index passes the driven value through
    for (int i = 8'h3c; i <= 8'h4a; i++)
      if (i != 8'h3e && i != 8'h3f && i != 8'h49)
        rchk(8'(i), (i == 8'h3c || i == 8'h48) ? 32'h1357_9bdf : 32'h9bdf, 1'b0, d);
    rchk(8'h39, 32'h0, 1'b1, d);
  endtask
  // Each stop kind from a jog, then the one-period ending state
  task automatic t_velocity();
    logic [31:0] d;
    for (int k = 1; k < 6; k++)
    begin
      pulse(0);
      rchk(dsr_pkg::IDX_VEL_STATE, 32'h1, 1'b0, d);
      u_dsr_host.wr(dsr_pkg::IDX_VEL_STATE);
      rchk(dsr_pkg::IDX_VEL_STATE, 32'h1, 1'b0, d);
      pulse(k);
      rchk(dsr_pkg::IDX_VEL_STATE, k > 3 ? 32'h2 : 32'h3, 1'b0, d);
      pulse(6);
      rchk(dsr_pkg::IDX_VEL_STATE, 32'h4, 1'b0, d);
      cyc(7700);
      rchk(dsr_pkg::IDX_VEL_STATE, 32'h4, 1'b0, d);
      cyc(60);
      rchk(dsr_pkg::IDX_VEL_STATE, 32'h0, 1'b0, d);
    end
  endtask
  // Each feed move through brake, calculation, speed changes, then a kill, an immediate stop or a decel
  task automatic t_point();
    logic [31:0] d;
    for (int f = 7; f < 10; f++)
    begin
      pulse(f);
      rchk(dsr_pkg::IDX_PT_STATE, 32'h1, 1'b0, d);
      pulse(10);
      rchk(dsr_pkg::IDX_PT_STATE, 32'h2, 1'b0, d);
      pulse(11);
      rchk(dsr_pkg::IDX_PT_STATE, 32'h3, 1'b0, d);
      pulse(13);
      rchk(dsr_pkg::IDX_PT_STATE, 32'h4, 1'b0, d);
      pulse(12);
      rchk(dsr_pkg::IDX_PT_STATE, 32'h5, 1'b0, d);
      pulse(f == 7 ? 5 : (f == 8 ? 4 : 14));
      rchk(dsr_pkg::IDX_PT_STATE, f == 9 ? 32'h6 : 32'h7, 1'b0, d);
      pulse(6);
      rchk(dsr_pkg::IDX_PT_STATE, 32'h8, 1'b0, d);
      cyc(7700);
      rchk(dsr_pkg::IDX_PT_STATE, 32'h8, 1'b0, d);
      cyc(57);
      rchk(dsr_pkg::IDX_PT_STATE, 32'h0, 1'b0, d);
    end
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    fails = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    layout_sel = 2'h0;
    stepper_variant = 1'b0;
    stall_enable = 1'b0;
    pins = 16'h0;
    ext = 13'h0;
    ana = 16'h0;
    live = 32'h0;
    ev = 15'h0;
    cyc(20);
    sys_rst <= 1'b0;
    t_layouts();
    t_values();
    t_velocity();
    t_point();
    complete_run();
  end
endmodule
